//--- design/lfmsr_pkg.sv
package lfmsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FAULT_SUMMARY = 8'h03;
  localparam logic [7:0] ADDR_UNUSED_LO_FIRST = 8'h04;
  localparam logic [7:0] ADDR_UNUSED_LO_LAST = 8'h07;
  localparam logic [7:0] ADDR_FAULT_PROPAGATION_MASK = 8'h08;
  localparam logic [7:0] ADDR_OPEN_STRING_STATUS = 8'h09;
  localparam logic [7:0] ADDR_SHORTED_LED_STATUS = 8'h0a;
  localparam logic [7:0] ADDR_UNUSED_HI_FIRST = 8'h0b;
  localparam logic [7:0] ADDR_UNUSED_HI_LAST = 8'h0d;
  localparam logic [7:0] ADDR_GLOBAL_CURRENT_SCALE = 8'h0e;
  localparam logic [7:0] ADDR_RESERVED_FIXED_VALUE = 8'h10;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FAULT_PROPAGATION_MASK = 8'h0f;
  localparam logic [7:0] RST_GLOBAL_CURRENT_SCALE = 8'h7f;
  localparam logic [7:0] RST_RESERVED_FIXED_VALUE = 8'h04;
  localparam logic [3:0] RST_STRING_STATUS = 4'h0;
  localparam logic [7:0] CURRENT_SCALE_FULL = 8'hff;
  localparam logic [7:0] CURRENT_SCALE_MIN_ADVISED = 8'h05;
  localparam int SUMMARY_PIN_DRIVE_BIT = 0;
  localparam int SUMMARY_OPEN_BIT = 2;
  localparam int SUMMARY_SHORT_BIT = 3;

endpackage

//--- design/lfmsr_status_bit.sv
module lfmsr_status_bit (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic fault_in,
  input wire logic enable_in,
  input wire logic clear_in,
  output logic status_out
);

  logic status_ff;

  // ----------------------------------------------------------------
  // Sticky status with clear on read
  // ----------------------------------------------------------------
  // Set wins over the read clear so a fault in the clearing cycle survives
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_ff <= 1'b0;
    end else if (enable_in && fault_in) begin
      status_ff <= 1'b1;
    end else if (clear_in) begin
      status_ff <= 1'b0;
    end
  end

  assign status_out = status_ff;

endmodule

//--- design/lfmsr_top.sv
// Contract
// - Mask bit one lets that string's open and short faults reach the summary.
// - Fault output asserts only for faults passed by the mask.
// - Status bit 0..3 sets once the string's fault is verified.
// - Reading open or short status clears that whole register.
// - A clearing read leaves set the bit of a fault that persists.
// - Open faults recorded only with open enable; shorts only with short enable.
// - Sink check disable suppresses all open detection regardless of enable.
// - Eight-bit current scale applies to all strings as value over 255.
// - Scale offers 255 even steps of full scale over 255.
// - Current scale register resets to 0x7F.
// - Reserved register at 0x10 resets to 0x04.
// - Reading the reserved register returns it and leaves it unchanged.
// - Addresses 0x04 to 0x07 have no function.
// - Addresses 0x0B to 0x0D have no function.
// - Open or short summary bit sets when any passed status bit is set.
// - Pin drive flag sets on either summary bit; it pulls fault output low.
// - Configuration bit 2 is the open-detect enable.
// - Configuration bit 3 is the short-detect enable.
module lfmsr_top #(
  parameter int NUM_STRINGS = 4,
  parameter int DATA_W = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // Byte access from the serial slave front end
  input wire logic REG_WR_EN_IN,
  input wire logic REG_RD_EN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [DATA_W-1:0] REG_WDATA_IN,
  output logic [DATA_W-1:0] REG_RDATA_OUT,
  // Configuration bits held elsewhere in the device
  input wire logic OPEN_DETECT_ENABLE_IN,
  input wire logic SHORT_DETECT_ENABLE_IN,
  input wire logic SINK_CHECK_DISABLE_IN,
  // Verified fault levels per string from the analog monitors
  input wire logic [NUM_STRINGS-1:0] OPEN_FAULT_IN,
  input wire logic [NUM_STRINGS-1:0] SHORT_FAULT_IN,
  // Results
  output logic [DATA_W-1:0] CURRENT_SCALE_OUT,
  output logic [DATA_W-1:0] FAULT_SUMMARY_OUT,
  output logic FAULT_OUTPUT_N_OUT,
  output logic FAULT_OUTPUT_N_OE_OUT,
  output logic SCALE_BELOW_ADVISED_OUT
);

  logic [3:0] fault_propagation_mask_ff;
  logic [DATA_W-1:0] global_current_scale_ff;
  logic [DATA_W-1:0] reserved_fixed_value_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] fault_summary_ff;
  logic fault_pin_drive_flag_ff;
  logic fault_output_oe_n_ff;
  logic scale_low_ff;
  logic [NUM_STRINGS-1:0] open_string_status;
  logic [NUM_STRINGS-1:0] shorted_led_status;
  logic open_detect_enable;
  logic short_detect_enable;
  logic clear_open;
  logic clear_short;
  logic open_fault_summary_bit;
  logic short_fault_summary_bit;
  logic wr_mask;
  logic wr_scale;
  logic wr_reserved;

  // ----------------------------------------------------------------
  // Detect gating
  // ----------------------------------------------------------------
  // Sink check disable overrides the open enable entirely
  assign open_detect_enable = OPEN_DETECT_ENABLE_IN && !SINK_CHECK_DISABLE_IN;
  assign short_detect_enable = SHORT_DETECT_ENABLE_IN;

  // Read strobes clear the status registers
  assign clear_open = REG_RD_EN_IN && (REG_ADDR_IN == lfmsr_pkg::ADDR_OPEN_STRING_STATUS);
  assign clear_short = REG_RD_EN_IN && (REG_ADDR_IN == lfmsr_pkg::ADDR_SHORTED_LED_STATUS);

  // ----------------------------------------------------------------
  // Per-string status bits
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_STRINGS; g = g + 1) begin : gen_str
      lfmsr_status_bit u_open (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .fault_in(OPEN_FAULT_IN[g]),
        .enable_in(open_detect_enable),
        .clear_in(clear_open),
        .status_out(open_string_status[g])
      );
      lfmsr_status_bit u_short (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .fault_in(SHORT_FAULT_IN[g]),
        .enable_in(short_detect_enable),
        .clear_in(clear_short),
        .status_out(shorted_led_status[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Unused addresses decode to nothing, so writes there are dropped
  assign wr_mask = REG_WR_EN_IN && (REG_ADDR_IN == lfmsr_pkg::ADDR_FAULT_PROPAGATION_MASK);
  assign wr_scale = REG_WR_EN_IN && (REG_ADDR_IN == lfmsr_pkg::ADDR_GLOBAL_CURRENT_SCALE);
  assign wr_reserved = REG_WR_EN_IN && (REG_ADDR_IN == lfmsr_pkg::ADDR_RESERVED_FIXED_VALUE);

  // Mask keeps four bits, upper bits read zero
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      fault_propagation_mask_ff <= lfmsr_pkg::RST_FAULT_PROPAGATION_MASK[3:0];
    end else if (wr_mask) begin
      fault_propagation_mask_ff <= REG_WDATA_IN[3:0];
    end
  end

  // Global scale shared by every string sink
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      global_current_scale_ff <= lfmsr_pkg::RST_GLOBAL_CURRENT_SCALE;
    end else if (wr_scale) begin
      global_current_scale_ff <= REG_WDATA_IN;
    end
  end

  // Stored as written; the host is trusted to write only the fixed value
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      reserved_fixed_value_ff <= lfmsr_pkg::RST_RESERVED_FIXED_VALUE;
    end else if (wr_reserved) begin
      reserved_fixed_value_ff <= REG_WDATA_IN;
    end
  end

  // ----------------------------------------------------------------
  // Fault summary and fault pin
  // ----------------------------------------------------------------
  assign open_fault_summary_bit = |(open_string_status & fault_propagation_mask_ff[NUM_STRINGS-1:0]);
  assign short_fault_summary_bit = |(shorted_led_status & fault_propagation_mask_ff[NUM_STRINGS-1:0]);

  // Summary follows live status, so a clearing read releases the pin
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      fault_summary_ff <= '0;
      fault_pin_drive_flag_ff <= 1'b0;
    end else begin
      fault_summary_ff <= '0;
      fault_summary_ff[lfmsr_pkg::SUMMARY_OPEN_BIT] <= open_fault_summary_bit;
      fault_summary_ff[lfmsr_pkg::SUMMARY_SHORT_BIT] <= short_fault_summary_bit;
      fault_summary_ff[lfmsr_pkg::SUMMARY_PIN_DRIVE_BIT] <= open_fault_summary_bit | short_fault_summary_bit;
      fault_pin_drive_flag_ff <= open_fault_summary_bit | short_fault_summary_bit;
    end
  end

  // Pin enable kept in its own flop so the output needs no inverter
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      fault_output_oe_n_ff <= 1'b1;
    end else begin
      fault_output_oe_n_ff <= !(open_fault_summary_bit | short_fault_summary_bit);
    end
  end

  // Advisory flag for scale values that risk false short faults
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      scale_low_ff <= 1'b0;
    end else begin
      scale_low_ff <= global_current_scale_ff < lfmsr_pkg::CURRENT_SCALE_MIN_ADVISED;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    case (REG_ADDR_IN)
      lfmsr_pkg::ADDR_FAULT_PROPAGATION_MASK: nxt_rdata[3:0] = fault_propagation_mask_ff;
      lfmsr_pkg::ADDR_OPEN_STRING_STATUS: nxt_rdata[NUM_STRINGS-1:0] = open_string_status;
      lfmsr_pkg::ADDR_SHORTED_LED_STATUS: nxt_rdata[NUM_STRINGS-1:0] = shorted_led_status;
      lfmsr_pkg::ADDR_GLOBAL_CURRENT_SCALE: nxt_rdata = global_current_scale_ff;
      lfmsr_pkg::ADDR_RESERVED_FIXED_VALUE: nxt_rdata = reserved_fixed_value_ff;
      default: nxt_rdata = '0;
    endcase
  end

  // Data is captured at the read strobe and held until the next read
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      rdata_ff <= '0;
    end else if (REG_RD_EN_IN) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REG_RDATA_OUT = rdata_ff;
  assign CURRENT_SCALE_OUT = global_current_scale_ff;
  assign FAULT_SUMMARY_OUT = fault_summary_ff;
  // Open drain: data always low, enable low while pulling
  assign FAULT_OUTPUT_N_OUT = 1'b0;
  assign FAULT_OUTPUT_N_OE_OUT = fault_output_oe_n_ff;
  assign SCALE_BELOW_ADVISED_OUT = scale_low_ff;

endmodule

//--- bench/lfmsr_chk.sv
module lfmsr_chk #(
  parameter int NUM_STRINGS = 4,
  parameter int DATA_W = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic REG_WR_EN_IN,
  input wire logic REG_RD_EN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [DATA_W-1:0] REG_WDATA_IN,
  input wire logic [DATA_W-1:0] REG_RDATA_OUT,
  input wire logic OPEN_DETECT_ENABLE_IN,
  input wire logic SHORT_DETECT_ENABLE_IN,
  input wire logic SINK_CHECK_DISABLE_IN,
  input wire logic [NUM_STRINGS-1:0] OPEN_FAULT_IN,
  input wire logic [NUM_STRINGS-1:0] SHORT_FAULT_IN,
  input wire logic [DATA_W-1:0] FAULT_SUMMARY_OUT,
  input wire logic FAULT_OUTPUT_N_OE_OUT
);
  timeunit 1ns / 1ps;
  // ----------------
  // Properties
  // ----------------
  logic [3:0] mask_ff;
  // Shadow of the mask, since it is not visible at the ports
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      mask_ff <= 4'hf;
    end else if (REG_WR_EN_IN && REG_ADDR_IN == 8'h08) begin
      mask_ff <= REG_WDATA_IN[3:0];
    end
  end
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  property p_oe; FAULT_OUTPUT_N_OE_OUT == !FAULT_SUMMARY_OUT[0]; endproperty
  property p_flag; FAULT_SUMMARY_OUT[0] == |FAULT_SUMMARY_OUT[3:2]; endproperty
  property p_open;
    |(OPEN_FAULT_IN & mask_ff) && OPEN_DETECT_ENABLE_IN && !SINK_CHECK_DISABLE_IN |-> ##2 FAULT_SUMMARY_OUT[2];
  endproperty
  property p_short; |(SHORT_FAULT_IN & mask_ff) && SHORT_DETECT_ENABLE_IN |-> ##2 FAULT_SUMMARY_OUT[3]; endproperty
  property p_mask; mask_ff == 4'h0 && $past(mask_ff) == 4'h0 |-> FAULT_SUMMARY_OUT == 8'h00; endproperty
  property p_rsvd; REG_RD_EN_IN && REG_ADDR_IN == 8'h10 |=> REG_RDATA_OUT == 8'h04; endproperty
  property p_unused;
    REG_RD_EN_IN && REG_ADDR_IN inside {[8'h04:8'h07], [8'h0b:8'h0d]} |=> REG_RDATA_OUT == 8'h00;
  endproperty
  property p_hi; REG_RD_EN_IN && REG_ADDR_IN inside {8'h09, 8'h0a} |=> REG_RDATA_OUT[7:4] == 4'h0; endproperty
  a_oe: assert property (p_oe) else $error("fault pin enable disagrees with drive flag");
  a_flag: assert property (p_flag) else $error("drive flag disagrees with summary bits");
  a_open: assert property (p_open) else $error("open fault missing from summary");
  a_short: assert property (p_short) else $error("short fault missing from summary");
  a_mask: assert property (p_mask) else $error("masked fault reached summary");
  a_rsvd: assert property (p_rsvd) else $error("reserved read changed");
  a_unused: assert property (p_unused) else $error("unused address read nonzero");
  a_hi: assert property (p_hi) else $error("status upper bits nonzero");
  cover property (FAULT_SUMMARY_OUT[2]);
  cover property (FAULT_SUMMARY_OUT[3]);
  cover property (REG_RD_EN_IN && REG_ADDR_IN == 8'h09 ##1 REG_RDATA_OUT != 8'h00);
endmodule
bind lfmsr_top lfmsr_chk #(.NUM_STRINGS(NUM_STRINGS), .DATA_W(DATA_W)) u_lfmsr_chk (.*);

//--- bench/lfmsr_host.sv
module lfmsr_host (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic wr_en_out = 1'b0,
  output logic rd_en_out = 1'b0,
  output logic [7:0] addr_out = 8'h00,
  output logic [7:0] wdata_out = 8'h00
);
  timeunit 1ns / 1ps;
  // ----------------
  // Host accesses
  // ----------------
  // Host never asks for a scale that hurts accuracy
  task wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h0e && d < 8'h05) begin
      d = 8'h05;
    end
    if (a == 8'h10) begin
      d = 8'h04;
    end
    @(negedge clk_in);
    wr_en_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_en_out = 1'b0;
    addr_out = ~a; // Idle lines do not keep the last value
    wdata_out = ~d;
  endtask
  // Data is taken one cycle after the strobe
  task rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk_in);
    rd_en_out = 1'b1;
    addr_out = a;
    @(negedge clk_in);
    rd_en_out = 1'b0;
    addr_out = ~a;
    q = rdata_in;
  endtask
endmodule

//--- bench/lfmsr_top_test.sv
module lfmsr_top_test;
  timeunit 1ns / 1ps;
  // ----------------
  // Harness
  // ----------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_en = 1'b0, sh_en = 1'b0, dis = 1'b0;
  logic [3:0] of = 4'h0, sf = 4'h0;
  logic wr, rd, oe_n, pin_d, low;
  logic [7:0] addr, wdata, rdata, scale, summ;
  int failures = 0, n_compared = 0, cycles = 0;
  initial forever #10 clk = ~clk;
  lfmsr_top u_lfmsr_top (.REF_CLK_IN(clk), .RST_IN(rst), .REG_WR_EN_IN(wr), .REG_RD_EN_IN(rd),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .OPEN_DETECT_ENABLE_IN(op_en),
    .SHORT_DETECT_ENABLE_IN(sh_en), .SINK_CHECK_DISABLE_IN(dis), .OPEN_FAULT_IN(of), .SHORT_FAULT_IN(sf),
    .CURRENT_SCALE_OUT(scale), .FAULT_SUMMARY_OUT(summ), .FAULT_OUTPUT_N_OUT(pin_d),
    .FAULT_OUTPUT_N_OE_OUT(oe_n), .SCALE_BELOW_ADVISED_OUT(low));
  lfmsr_host u_lfmsr_host (.clk_in(clk), .rdata_in(rdata), .wr_en_out(wr), .rd_en_out(rd),
    .addr_out(addr), .wdata_out(wdata));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    u_lfmsr_host.rd(a, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task stop_test();
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Cut a hang short, far beyond the hundred or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      stop_test();
    end
  end
  // ----------------
  // Tests
  // ----------------
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    // Unused writes first, so side effects show in the reset reads
    for (int a = 4; a < 14; a++) begin
      if (a < 8 || a > 10) begin
        u_lfmsr_host.wr(8'(a), 8'hff);
        rc(8'(a), 8'h00);
      end
    end
    rc(8'h08, 8'h0f);
    rc(8'h0e, 8'h7f);
    rc(8'h10, 8'h04);
    rc(8'h10, 8'h04);
    rc(8'h09, 8'h00);
    rc(8'h0a, 8'h00);
    u_lfmsr_host.wr(8'h0e, 8'hff);
    chk("scale", 8'hff, scale);
    u_lfmsr_host.wr(8'h0e, 8'h05);
    rc(8'h0e, 8'h05);
    chk("low", 8'h00, {7'h0, low});
    // Open fault reported, persists, then clears
    op_en = 1'b1;
    of = 4'h1;
    repeat (3) @(negedge clk);
    chk("summary", 8'h05, summ);
    chk("oe", 8'h00, {7'h0, oe_n});
    chk("pin", 8'h00, {7'h0, pin_d});
    rc(8'h09, 8'h01);
    rc(8'h09, 8'h01);
    of = 4'h0;
    rc(8'h09, 8'h01);
    rc(8'h09, 8'h00);
    repeat (2) @(negedge clk);
    chk("oe", 8'h01, {7'h0, oe_n});
    // Suppressed and disabled detection
    dis = 1'b1;
    of = 4'hf;
    sf = 4'hf;
    repeat (3) @(negedge clk);
    rc(8'h09, 8'h00);
    rc(8'h0a, 8'h00);
    dis = 1'b0;
    op_en = 1'b0;
    repeat (3) @(negedge clk);
    rc(8'h09, 8'h00);
    of = 4'h0;
    sf = 4'h0;
    // Short fault held back by the mask, then let through
    u_lfmsr_host.wr(8'h08, 8'h00);
    sh_en = 1'b1;
    sf = 4'h2;
    repeat (3) @(negedge clk);
    chk("summary", 8'h00, summ);
    rc(8'h0a, 8'h02);
    u_lfmsr_host.wr(8'h08, 8'h02);
    repeat (2) @(negedge clk);
    chk("summary", 8'h09, summ);
    sf = 4'h0;
    rc(8'h0a, 8'h02);
    rc(8'h0a, 8'h00);
    stop_test();
  end
endmodule
